// ---- shared/lmaid_pkg.sv ----
// Purpose: Constants and types shared by the limit alert and identification block.
// Assumes: 16-bit registers reached through a register access port with one 8-bit address per register.
// Notes: Identification values are parameters of the top module.

package lmaid_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 8;

    localparam logic [7:0] OFF_ALERT_SEL = 8'h06;
    localparam logic [7:0] OFF_LIMIT = 8'h07;
    localparam logic [7:0] OFF_MAKER = 8'hfe;
    localparam logic [7:0] OFF_DIE = 8'hff;

    localparam int unsigned BIT_SHUNT_OVER = 15;
    localparam int unsigned BIT_SHUNT_UNDER = 14;
    localparam int unsigned BIT_BUS_OVER = 13;
    localparam int unsigned BIT_BUS_UNDER = 12;
    localparam int unsigned BIT_POWER_OVER = 11;
    localparam int unsigned BIT_CONV_ALERT = 10;
    localparam int unsigned BIT_LIMIT_FLAG = 4;
    localparam int unsigned BIT_CONV_FLAG = 3;
    localparam int unsigned BIT_OVF_FLAG = 2;
    localparam int unsigned BIT_POLARITY = 1;
    localparam int unsigned BIT_LATCH = 0;

    // Host-writable bits of the selection register; flags are read-only.
    localparam logic [15:0] ALERT_SEL_WMASK = 16'hfc03;
    localparam logic [15:0] ALERT_SEL_RESET = 16'h0000;
    localparam logic [15:0] LIMIT_RESET = 16'h0000;

    localparam int unsigned DIE_CODE_LSB = 4;
    localparam int unsigned DIE_REV_W = 4;

    typedef enum logic [2:0] {
        LMAID_FN_NONE,
        LMAID_FN_SHUNT_OVER,
        LMAID_FN_SHUNT_UNDER,
        LMAID_FN_BUS_OVER,
        LMAID_FN_BUS_UNDER,
        LMAID_FN_POWER_OVER
    } lmaid_fn_t;

    // Highest enabled function wins.
    function automatic lmaid_fn_t lmaid_pick_fn(input logic [15:0] sel);
        if (sel[BIT_SHUNT_OVER]) begin
            return LMAID_FN_SHUNT_OVER;
        end else if (sel[BIT_SHUNT_UNDER]) begin
            return LMAID_FN_SHUNT_UNDER;
        end else if (sel[BIT_BUS_OVER]) begin
            return LMAID_FN_BUS_OVER;
        end else if (sel[BIT_BUS_UNDER]) begin
            return LMAID_FN_BUS_UNDER;
        end else if (sel[BIT_POWER_OVER]) begin
            return LMAID_FN_POWER_OVER;
        end
        return LMAID_FN_NONE;
    endfunction

endpackage

// ---- shared/lmaid_cmp_if.sv ----
// Purpose: Carries the selected function, results and limit to the comparator.
// Assumes: Purely combinational traffic within one clock domain.
// Notes: The hit flag and the shunt-function flag come back on the same interface.
`timescale 1ns/100ps
`default_nettype none

interface lmaid_cmp_if;
    import lmaid_pkg::*;
    lmaid_fn_t fn;
    logic [DATA_W-1:0] shunt_val;
    logic [DATA_W-1:0] bus_val;
    logic [DATA_W-1:0] power_val;
    logic [DATA_W-1:0] limit_val;
    logic limit_hit;
    logic is_shunt_fn;

    modport ctrl (output fn, output shunt_val, output bus_val, output power_val,
        output limit_val, input limit_hit, input is_shunt_fn);
    modport cmp (input fn, input shunt_val, input bus_val, input power_val,
        input limit_val, output limit_hit, output is_shunt_fn);
endinterface

`default_nettype wire

// ---- core/lmaid_limit_cmp.sv ----
// Purpose: Compares the selected result against the alert limit.
// Assumes: Inputs are stable when the caller samples the result.
// Notes: Combinational; the caller registers the outcome.
`timescale 1ns/100ps
`default_nettype none

module lmaid_limit_cmp (
    lmaid_cmp_if.cmp cmp_bus
);
    import lmaid_pkg::*;

    always_comb begin
        cmp_bus.limit_hit = 1'b0;
        cmp_bus.is_shunt_fn = 1'b0;
        unique case (cmp_bus.fn)
            LMAID_FN_SHUNT_OVER: begin
                // Shunt readings are two's complement, so compare signed.
                cmp_bus.limit_hit = $signed(cmp_bus.shunt_val) > $signed(cmp_bus.limit_val);
                cmp_bus.is_shunt_fn = 1'b1;
            end
            LMAID_FN_SHUNT_UNDER: begin
                cmp_bus.limit_hit = $signed(cmp_bus.shunt_val) < $signed(cmp_bus.limit_val);
                cmp_bus.is_shunt_fn = 1'b1;
            end
            LMAID_FN_BUS_OVER: begin
                cmp_bus.limit_hit = cmp_bus.bus_val > cmp_bus.limit_val;
            end
            LMAID_FN_BUS_UNDER: begin
                cmp_bus.limit_hit = cmp_bus.bus_val < cmp_bus.limit_val;
            end
            LMAID_FN_POWER_OVER: begin
                cmp_bus.limit_hit = cmp_bus.power_val > cmp_bus.limit_val;
            end
            LMAID_FN_NONE: begin
                cmp_bus.limit_hit = 1'b0;
            end
            default: begin
                cmp_bus.limit_hit = 1'b0;
            end
        endcase
    end

endmodule // lmaid_limit_cmp

`default_nettype wire

// ---- core/lmaid_top.sv ----
// Purpose: Alert selection, flags, limit register and identification registers.
// Assumes: Measurement engine supplies results with a one-cycle end-of-cycle strobe.
// Notes: The alert pin is open collector; the pin output value is always low.
`timescale 1ns/100ps
`default_nettype none

module lmaid_top #(
    // Arbitrary neutral identification values.
    parameter logic [15:0] MAKER_CODE = 16'h0a5a,
    parameter logic [11:0] DIE_CODE = 12'h123,
    parameter logic [3:0] DIE_REV = 4'h1
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register access port.
    input wire logic [lmaid_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [lmaid_pkg::DATA_W-1:0] reg_wdata,
    output logic [lmaid_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // Measurement engine side.
    input wire logic cycle_done,
    input wire logic cycle_had_shunt,
    input wire logic cycle_had_bus,
    input wire logic cycle_math_ovf,
    input wire logic [lmaid_pkg::DATA_W-1:0] shunt_result,
    input wire logic [lmaid_pkg::DATA_W-1:0] bus_result,
    input wire logic [lmaid_pkg::DATA_W-1:0] power_result,
    input wire logic cfg_write,
    input wire logic cfg_write_powerdown,
    // Open-collector alert pin.
    output logic alert_pin_out,
    output logic alert_pin_oe,
    output logic alert_active
);
    import lmaid_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    lmaid_cmp_if cmp_bus ();

    lmaid_limit_cmp u_cmp (
        .cmp_bus(cmp_bus)
    );

    logic [15:0] sel_r;
    logic [15:0] sel_nxt;
    logic [15:0] limit_r;
    logic [15:0] limit_nxt;
    logic limit_flag_r;
    logic limit_flag_nxt;
    logic conv_flag_r;
    logic conv_flag_nxt;
    logic ovf_flag_r;
    logic ovf_flag_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic oe_r;
    logic oe_nxt;
    logic active_r;
    logic active_nxt;

    logic sel_read;
    logic sel_write;
    logic limit_write;
    logic evaluated;
    logic alert_cond;

    assign sel_read = reg_rd && (reg_addr == OFF_ALERT_SEL);
    assign sel_write = reg_wr && (reg_addr == OFF_ALERT_SEL);
    assign limit_write = reg_wr && (reg_addr == OFF_LIMIT);

    assign cmp_bus.fn = lmaid_pick_fn(sel_r);
    assign cmp_bus.shunt_val = shunt_result;
    assign cmp_bus.bus_val = bus_result;
    assign cmp_bus.power_val = power_result;
    assign cmp_bus.limit_val = limit_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Limit evaluation

    // A function is only judged on a cycle that produced its input; power follows
    // the bus measurement, so it rides on the bus strobe.
    always_comb begin
        evaluated = 1'b0;
        if (cycle_done && cmp_bus.fn != LMAID_FN_NONE) begin
            if (cmp_bus.is_shunt_fn) begin
                evaluated = cycle_had_shunt;
            end else begin
                evaluated = cycle_had_bus;
            end
        end
    end

    assign alert_cond = evaluated && cmp_bus.limit_hit;

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes and flags

    always_comb begin
        sel_nxt = sel_r;
        limit_nxt = limit_r;
        if (sel_write) begin
            sel_nxt = reg_wdata & ALERT_SEL_WMASK;
        end
        if (limit_write) begin
            limit_nxt = reg_wdata;
        end
    end

    always_comb begin
        limit_flag_nxt = limit_flag_r;
        if (sel_r[BIT_LATCH]) begin
            // A hit in the same cycle as the read survives the read.
            if (sel_read) begin
                limit_flag_nxt = 1'b0;
            end
            if (alert_cond) begin
                limit_flag_nxt = 1'b1;
            end
        end else begin
            if (evaluated) begin
                limit_flag_nxt = cmp_bus.limit_hit;
            end
        end
        if (cmp_bus.fn == LMAID_FN_NONE && !sel_r[BIT_LATCH]) begin
            limit_flag_nxt = 1'b0;
        end
    end

    always_comb begin
        conv_flag_nxt = conv_flag_r;
        if (sel_read || (cfg_write && !cfg_write_powerdown)) begin
            conv_flag_nxt = 1'b0;
        end
        if (cycle_done) begin
            conv_flag_nxt = 1'b1;
        end
    end

    always_comb begin
        ovf_flag_nxt = ovf_flag_r;
        if (cycle_done) begin
            ovf_flag_nxt = cycle_math_ovf;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register reads

    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = reg_rd;
        if (reg_rd) begin
            unique case (reg_addr)
                OFF_ALERT_SEL: begin
                    rdata_nxt = sel_r;
                    rdata_nxt[BIT_LIMIT_FLAG] = limit_flag_r;
                    rdata_nxt[BIT_CONV_FLAG] = conv_flag_r;
                    rdata_nxt[BIT_OVF_FLAG] = ovf_flag_r;
                end
                OFF_LIMIT: begin
                    rdata_nxt = limit_r;
                end
                OFF_MAKER: begin
                    rdata_nxt = MAKER_CODE;
                end
                OFF_DIE: begin
                    rdata_nxt = {DIE_CODE, DIE_REV};
                end
                default: begin
                    rdata_nxt = 16'h0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Alert pin

    // The pin is built from the next flag values, so it moves at the same edge as the flags.
    always_comb begin
        active_nxt = limit_flag_nxt || (sel_r[BIT_CONV_ALERT] && conv_flag_nxt);
        if (sel_r[BIT_POLARITY]) begin
            oe_nxt = !active_nxt;
        end else begin
            oe_nxt = active_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_r <= ALERT_SEL_RESET;
            limit_r <= LIMIT_RESET;
            limit_flag_r <= 1'b0;
            conv_flag_r <= 1'b0;
            ovf_flag_r <= 1'b0;
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
            oe_r <= 1'b0;
            active_r <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
            limit_r <= limit_nxt;
            limit_flag_r <= limit_flag_nxt;
            conv_flag_r <= conv_flag_nxt;
            ovf_flag_r <= ovf_flag_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            oe_r <= oe_nxt;
            active_r <= active_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign alert_pin_oe = oe_r;
    assign alert_pin_out = 1'b0;
    assign alert_active = active_r;

endmodule // lmaid_top

`default_nettype wire

// ---- bench/lmaid_props.sv ----
// Purpose: Port checks for the limit alert and identification block.
// Assumes: Registers change only through the register port.
// Notes: Helper flops mirror the host-written polarity, latch and limit.
`timescale 1ns/100ps
`default_nettype none

module lmaid_props #(
    parameter logic [15:0] MAKER_CODE = 16'h0a5a,
    parameter logic [11:0] DIE_CODE = 12'h123,
    parameter logic [3:0] DIE_REV = 4'h1
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [lmaid_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [lmaid_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [lmaid_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic cycle_done,
    input wire logic cfg_write,
    input wire logic alert_pin_out,
    input wire logic alert_pin_oe,
    input wire logic alert_active
);
    import lmaid_pkg::*;
    logic pol_r;
    logic lat_r;
    logic [15:0] lim_r;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pol_r <= 1'b0;
            lat_r <= 1'b0;
            lim_r <= LIMIT_RESET;
        end else if (reg_wr && reg_addr == OFF_ALERT_SEL) begin
            pol_r <= reg_wdata[BIT_POLARITY];
            lat_r <= reg_wdata[BIT_LATCH];
        end else if (reg_wr && reg_addr == OFF_LIMIT) begin
            lim_r <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read answer without request");
    a_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved without answer");
    a_maker_read: assert property (
        reg_rvalid && $past(reg_addr) == OFF_MAKER |-> reg_rdata == MAKER_CODE)
        else $error("maker code wrong");
    a_die_read: assert property (
        reg_rvalid && $past(reg_addr) == OFF_DIE |-> reg_rdata == {DIE_CODE, DIE_REV})
        else $error("die code wrong");
    a_limit_read: assert property (
        reg_rvalid && $past(reg_addr) == OFF_LIMIT |-> reg_rdata == lim_r)
        else $error("limit readback wrong");
    a_pin_low: assert property (alert_pin_out == 1'b0)
        else $error("alert pin driven high");
    a_pol_map: assert property (
        $past(cycle_done) |-> alert_pin_oe == (alert_active ^ pol_r))
        else $error("alert polarity wrong");
    // A read, config write or mode change may release the alert a cycle late.
    a_latch_hold: assert property (lat_r && alert_active && !reg_rd && !reg_wr
        && !cfg_write && !$past(reg_rd) && !$past(reg_wr) && !$past(cfg_write)
        |=> alert_active)
        else $error("latched alert released");
    a_active_cause: assert property ($changed(alert_active)
        |-> $past(cycle_done || reg_rd || reg_wr || cfg_write)
        || $past(reg_rd || reg_wr || cfg_write, 2))
        else $error("alert moved without cause");
endmodule // lmaid_props

bind lmaid_top lmaid_props #(.MAKER_CODE(MAKER_CODE), .DIE_CODE(DIE_CODE),
    .DIE_REV(DIE_REV)) u_props (.sys_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .cycle_done, .cfg_write,
    .alert_pin_out, .alert_pin_oe, .alert_active);

`default_nettype wire

// ---- bench/lmaid_host.sv ----
// Purpose: Host controller model on the register port.
// Assumes: Strobes launched at the falling edge, one word per access.
// Notes: Released address and data lines show the inverse value.
`timescale 1ns/100ps
`default_nettype none

module lmaid_host (
    input wire logic sys_clk,
    output logic [lmaid_pkg::ADDR_W-1:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [lmaid_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [lmaid_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    import lmaid_pkg::*;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // Reading the selection register is what releases a latched alert.
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rvalid ? reg_rdata : 16'hxxxx;
    endtask
endmodule // lmaid_host

`default_nettype wire

// ---- bench/tb_lmaid_top.sv ----
// Purpose: Self-checking bench for the limit alert block.
// Assumes: One clock, inputs driven at the falling edge.
// Notes: A reference model of flags and alert is kept in plain variables.
`timescale 1ns/100ps
`default_nettype none

module tb_lmaid_top;
    import lmaid_pkg::*;
    // Arbitrary identification values.
    localparam logic [15:0] MAKER_V = 16'h3c96;
    localparam logic [11:0] DIE_C = 12'h5a7;
    localparam logic [3:0] DIE_R = 4'h2;
    logic sys_clk, arst_n, reg_wr, reg_rd, reg_rvalid, cfg_write, cfg_write_powerdown;
    logic cycle_done, cycle_had_shunt, cycle_had_bus, cycle_math_ovf;
    logic alert_pin_out, alert_pin_oe, alert_active;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, shunt_result, bus_result, power_result;
    logic [15:0] m_sel, m_lim, rv, ch;
    logic m_aff, m_conv_done_flag, m_ovf;
    logic [31:0] rn;
    int err_total, tests_run, seed;

    lmaid_top #(.MAKER_CODE(MAKER_V), .DIE_CODE(DIE_C), .DIE_REV(DIE_R)) DUT (
        .sys_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid, .cycle_done, .cycle_had_shunt, .cycle_had_bus, .cycle_math_ovf,
        .shunt_result, .bus_result, .power_result, .cfg_write, .cfg_write_powerdown,
        .alert_pin_out, .alert_pin_oe, .alert_active);
    lmaid_host host (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid);

    ////////////////////////////////////////////////////////////
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t pin got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic rd_sel;
        host.rd(OFF_ALERT_SEL, rv);
        chk_reg(rv, m_sel | {11'h000, m_aff, m_conv_done_flag, m_ovf, 2'b00});
        m_conv_done_flag = 1'b0;
        if (m_sel[BIT_LATCH]) m_aff = 1'b0;
    endtask
    task automatic conv;
        logic ev, hit, act;
        int f;
        @(negedge sys_clk);
        rn = $random(seed);
        {shunt_result, bus_result} = rn;
        power_result = rn[23:8];
        {cycle_had_shunt, cycle_had_bus, cycle_math_ovf} = rn[2:0];
        cycle_done = 1'b1;
        @(negedge sys_clk);
        cycle_done = 1'b0;
        f = 0;
        ev = 1'b0;
        hit = 1'b0;
        for (int b = 11; b <= 15; b++) if (m_sel[b]) f = b;
        case (f)
            15: {ev, hit} = {cycle_had_shunt, $signed(shunt_result) > $signed(m_lim)};
            14: {ev, hit} = {cycle_had_shunt, $signed(shunt_result) < $signed(m_lim)};
            13: {ev, hit} = {cycle_had_bus, bus_result > m_lim};
            12: {ev, hit} = {cycle_had_bus, bus_result < m_lim};
            11: {ev, hit} = {cycle_had_bus, power_result > m_lim};
            default: ;
        endcase
        if (m_sel[BIT_LATCH]) m_aff = m_aff | (ev & hit);
        else if (f == 0) m_aff = 1'b0;
        else if (ev) m_aff = hit;
        m_conv_done_flag = 1'b1;
        m_ovf = cycle_math_ovf;
        act = m_aff | (m_sel[BIT_CONV_ALERT] & m_conv_done_flag);
        chk_pin(alert_active, act);
        chk_pin(alert_pin_oe, act ^ m_sel[BIT_POLARITY]);
        chk_pin(alert_pin_out, 1'b0);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        err_total++;
        end_of_test;
    end
    initial begin
        {seed, err_total, tests_run} = {32'hc0c1, 64'h0};
        {arst_n, cycle_done, cfg_write, cfg_write_powerdown} = 4'h0;
        {cycle_had_shunt, cycle_had_bus, cycle_math_ovf} = 3'h0;
        {shunt_result, bus_result, power_result} = 48'h0;
        {m_sel, m_lim, m_aff, m_conv_done_flag, m_ovf} = 35'h0;
        repeat (3) @(negedge sys_clk);
        arst_n = 1'b1;
        rd_sel;
        host.rd(OFF_LIMIT, rv);
        chk_reg(rv, LIMIT_RESET);
        for (int i = 0; i < 40; i++) begin
            rn = $random(seed);
            ch = 16'h0800 << (i % 5);
            host.wr(OFF_ALERT_SEL, (rn[15:0] & (ch - 16'h0001)) | ch);
            m_sel = ((rn[15:0] & (ch - 16'h0001)) | ch) & ALERT_SEL_WMASK;
            m_lim = rn[31:16];
            host.wr(OFF_LIMIT, m_lim);
            host.rd(OFF_LIMIT, rv);
            chk_reg(rv, m_lim);
            repeat (3) begin
                conv;
                rn = $random(seed);
                if (rn[0]) begin
                    @(negedge sys_clk);
                    {cfg_write, cfg_write_powerdown} = {1'b1, rn[1]};
                    @(negedge sys_clk);
                    cfg_write = 1'b0;
                    if (!rn[1]) m_conv_done_flag = 1'b0;
                end
                if (rn[2]) rd_sel;
            end
        end
        // Conversion alert alone, with no limit function, in transparent mode.
        host.wr(OFF_ALERT_SEL, 16'h0001 << BIT_CONV_ALERT);
        m_sel = 16'h0001 << BIT_CONV_ALERT;
        conv;
        host.wr(OFF_MAKER, 16'hffff);
        host.wr(OFF_DIE, 16'hffff);
        host.rd(OFF_MAKER, rv);
        chk_reg(rv, MAKER_V);
        host.rd(OFF_DIE, rv);
        chk_reg(rv, {DIE_C, DIE_R});
        host.rd(8'h10, rv);
        chk_reg(rv, 16'h0000);
        @(negedge sys_clk);
        arst_n = 1'b0;
        {m_sel, m_lim, m_aff, m_conv_done_flag, m_ovf} = 35'h0;
        @(negedge sys_clk);
        arst_n = 1'b1;
        chk_pin(alert_pin_oe, 1'b0);
        chk_pin(alert_active, 1'b0);
        rd_sel;
        end_of_test;
    end
endmodule // tb_lmaid_top

`default_nettype wire
